/* hdl/stp_link_if.sv */
// Link between the framer transmit payload input and the system payload source
`timescale 1ns/10ps
interface stp_link_if;
    logic transmit_serial_payload;
    logic transmit_frame_reference;
    logic transmit_frame_boundary;
    logic transmit_overhead_indicator;

    modport dev
    (
        input transmit_serial_payload,
        input transmit_frame_reference,
        output transmit_frame_boundary,
        output transmit_overhead_indicator
    );

    modport sys
    (
        output transmit_serial_payload,
        output transmit_frame_reference,
        input transmit_frame_boundary,
        input transmit_overhead_indicator
    );
endinterface

/* hdl/stp_pkg.sv */
// Shared constants and types for the serial transmit payload link
package stp_pkg;

    // Device mode register and its timing reference select field
    localparam logic [15:0] STP_MODE_REG_ADDR = 16'h1100;
    localparam int STP_TRS_LSB = 0;
    localparam int STP_TRS_MSB = 1;
    localparam logic [7:0] STP_MODE_RESET = 8'h00;

    // Outbound frame layout: one overhead bit then 84 payload bits, 56 blocks
    localparam int STP_FRAME_BITS = 4760;
    localparam int STP_BLOCK_BITS = 85;
    localparam int STP_BYTE_BITS = 8;

    // Controller registers on AXI4-Lite
    localparam logic [7:0] STP_CTRL_ADDR = 8'h00;
    localparam logic [7:0] STP_STATUS_ADDR = 8'h04;
    localparam logic [7:0] STP_PATTERN_ADDR = 8'h08;
    localparam int STP_CTRL_TRS_LSB = 0;
    localparam int STP_CTRL_EN_BIT = 2;
    localparam logic [2:0] STP_CTRL_RESET = 3'h0;
    localparam logic [7:0] STP_PATTERN_RESET = 8'hA5;
    localparam logic [1:0] STP_RESP_OKAY = 2'h0;
    localparam logic [1:0] STP_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0]
    {
        STP_TM_LOOP = 2'h0,
        STP_TM_SLAVE = 2'h1,
        STP_TM_MASTER = 2'h3
    } stp_tmode_t;

    typedef enum logic [1:0]
    {
        STP_HS_IDLE = 2'h0,
        STP_HS_START = 2'h1,
        STP_HS_RUN = 2'h3
    } stp_hstate_t;

    // Upper bit set selects master whatever the lower bit
    function automatic stp_tmode_t stp_decode_mode(input logic [1:0] sel);
        if (sel[1])
        begin
            return STP_TM_MASTER;
        end
        return sel[0] ? STP_TM_SLAVE : STP_TM_LOOP;
    endfunction

endpackage

/* hdl/stp_tx_payload_dev.sv */
// Framer end: serial transmit payload input in local-timing modes
//
// What this block does
// [RULE1] Width select pin low means serial payload
// [RULE2] Timing select field sits in mode register bits 1:0
// [RULE3] Field 01 selects local-timing frame-slave mode
// [RULE4] Upper field bit set selects frame-master mode
// [RULE5] Local timing runs on the shared input clock
// [RULE6] System feeds one clock to both ends
// [RULE7] System changes payload bit on rising edge
// [RULE8] Payload bit captured on every rising edge outside overhead slots
// [RULE9] Frame boundary high one bit at last bit
// [RULE10] System starts next frame after boundary pulse
// [RULE11] Master mode times frames by itself
// [RULE12] Master mode ignores the frame reference input
// [RULE13] System grounds frame reference in master mode
// [RULE14] Overhead indicator pulses one bit before overhead
// [RULE15] System holds next payload bit after indicator
// [RULE16] Overhead positions are not taken from input
// [RULE17] Slave mode restarts frame on reference rising edge
// [RULE18] System pulses reference with first frame bit
// [RULE19] Field 00 selects loop timing, not local
// [RULE20] Bit position counter times indicator and boundary
`timescale 1ns/10ps
module stp_tx_payload_dev
    import stp_pkg::*;
#(
    parameter int FRAME_BITS = STP_FRAME_BITS,
    parameter int BLOCK_BITS = STP_BLOCK_BITS
)
(
    input wire logic aclk,
    input wire logic aresetn,
    stp_link_if.dev link,
    input wire logic payload_width_select_pin,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    output logic [7:0] reg_rdata,
    output logic [7:0] payload_byte,
    output logic payload_byte_valid,
    output logic frame_done,
    output logic local_timing_active
);

    localparam int PW = $clog2(FRAME_BITS);
    localparam int BW = $clog2(BLOCK_BITS);
    localparam logic [PW-1:0] POS_LAST = PW'(FRAME_BITS - 1);
    localparam logic [BW-1:0] BLK_LAST = BW'(BLOCK_BITS - 1);
    localparam logic [2:0] BIT_LAST = 3'(STP_BYTE_BITS - 1);

    logic [7:0] mode_q;
    logic [7:0] rdata_q;
    logic wsel_meta_q;
    logic wsel_q;
    logic ref_prev_q;
    logic [PW-1:0] pos_q;
    logic [PW-1:0] pos_d;
    logic [BW-1:0] blk_q;
    logic [BW-1:0] blk_d;
    logic [PW-1:0] cur_pos;
    logic [BW-1:0] cur_blk;
    logic boundary_q;
    logic oh_ind_q;
    logic [7:0] shift_q;
    logic [2:0] bitcnt_q;
    logic [7:0] byte_q;
    logic byte_valid_q;
    logic frame_done_q;
    stp_tmode_t tmode;
    logic serial_sel;
    logic run;
    logic restart;
    logic overhead_now;

    ////////////////////////////////////////////////////////////////////////////
    // Mode register, reached through the device's own register port

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mode_q <= STP_MODE_RESET;
        end
        else if (reg_write && reg_addr == STP_MODE_REG_ADDR)
        begin
            mode_q <= reg_wdata; // [RULE2]
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata_q <= 8'h00;
        end
        else
        begin
            rdata_q <= (reg_addr == STP_MODE_REG_ADDR) ? mode_q : 8'h00;
        end
    end

    assign tmode = stp_decode_mode(mode_q[STP_TRS_MSB:STP_TRS_LSB]); // [RULE2] [RULE3] [RULE4] [RULE19]

    ////////////////////////////////////////////////////////////////////////////
    // Width select strap comes from a board pin, so it is synchronised

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wsel_meta_q <= 1'b0;
            wsel_q <= 1'b0;
        end
        else
        begin
            wsel_meta_q <= payload_width_select_pin;
            wsel_q <= wsel_meta_q;
        end
    end

    assign serial_sel = !wsel_q; // [RULE1]

    // Loop timing and nibble width are handled elsewhere; this path idles
    assign run = serial_sel && (tmode != STP_TM_LOOP); // [RULE1] [RULE5] [RULE19]

    ////////////////////////////////////////////////////////////////////////////
    // Frame reference: same-clock logic on the far side, no synchroniser

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ref_prev_q <= 1'b0;
        end
        else
        begin
            ref_prev_q <= link.transmit_frame_reference;
        end
    end

    // Master mode never looks at the reference, so an unsynchronised pin is harmless
    assign restart = run && (tmode == STP_TM_SLAVE) && link.transmit_frame_reference
        && !ref_prev_q; // [RULE3] [RULE17] [RULE11] [RULE12] [RULE18]

    ////////////////////////////////////////////////////////////////////////////
    // Bit position counters; the restart bit is itself position zero

    always_comb
    begin
        cur_pos = restart ? '0 : pos_q; // [RULE17]
        cur_blk = restart ? '0 : blk_q;
        if (cur_pos == POS_LAST)
        begin
            pos_d = '0;
            blk_d = '0;
        end
        else
        begin
            pos_d = cur_pos + PW'(1); // [RULE20]
            blk_d = (cur_blk == BLK_LAST) ? '0 : cur_blk + BW'(1);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run)
        begin
            pos_q <= '0;
            blk_q <= '0;
        end
        else
        begin
            pos_q <= pos_d; // [RULE5] [RULE11] [RULE20]
            blk_q <= blk_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobes to the system, registered from the next bit position

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run)
        begin
            boundary_q <= 1'b0;
            oh_ind_q <= 1'b0;
        end
        else
        begin
            boundary_q <= (pos_d == POS_LAST); // [RULE9]
            oh_ind_q <= (blk_d == BLK_LAST); // [RULE14]
        end
    end

    assign link.transmit_frame_boundary = boundary_q;
    assign link.transmit_overhead_indicator = oh_ind_q;

    ////////////////////////////////////////////////////////////////////////////
    // Payload capture; overhead slots carry a filler bit that is dropped

    assign overhead_now = (cur_blk == '0);

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !run)
        begin
            shift_q <= 8'h00;
            bitcnt_q <= 3'h0;
        end
        else if (cur_pos == '0)
        begin
            bitcnt_q <= 3'h0; // [RULE16]
        end
        else if (!overhead_now)
        begin
            shift_q <= {shift_q[6:0], link.transmit_serial_payload}; // [RULE8]
            bitcnt_q <= bitcnt_q + 3'h1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            byte_q <= 8'h00;
            byte_valid_q <= 1'b0;
        end
        else
        begin
            byte_valid_q <= 1'b0;
            if (run && !overhead_now && cur_pos != '0 && bitcnt_q == BIT_LAST)
            begin
                byte_q <= {shift_q[6:0], link.transmit_serial_payload}; // [RULE8] [RULE16]
                byte_valid_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            frame_done_q <= 1'b0;
        end
        else
        begin
            frame_done_q <= run && (cur_pos == POS_LAST);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // User-side outputs

    assign reg_rdata = rdata_q;
    assign payload_byte = byte_q;
    assign payload_byte_valid = byte_valid_q;
    assign frame_done = frame_done_q;
    assign local_timing_active = run;

endmodule // stp_tx_payload_dev

/* hdl/stp_tx_payload_sys.sv */
// System end: serial payload source with AXI4-Lite control registers
`timescale 1ns/10ps
module stp_tx_payload_sys
    import stp_pkg::*;
#(
    parameter int AW = 8
)
(
    input wire logic aclk,
    input wire logic aresetn,
    stp_link_if.sys link,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    logic [2:0] ctrl_q;
    logic [7:0] pattern_q;
    logic [15:0] frames_q;
    logic aw_got_q;
    logic w_got_q;
    logic [AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic do_write;
    stp_hstate_t state_q;
    logic data_q;
    logic ref_q;
    logic [2:0] idx_q;
    stp_tmode_t tmode;
    logic enable;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data taken in either order

    assign s_axi_awready = !aw_got_q && !bvalid_q;
    assign s_axi_wready = !w_got_q && !bvalid_q;
    assign do_write = aw_got_q && w_got_q && !bvalid_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= STP_RESP_OKAY;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_write)
            begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (awaddr_q == STP_CTRL_ADDR || awaddr_q == STP_PATTERN_ADDR
                    || awaddr_q == STP_STATUS_ADDR) ? STP_RESP_OKAY : STP_RESP_SLVERR;
            end
            else if (bvalid_q && s_axi_bready)
            begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_q <= STP_CTRL_RESET;
            pattern_q <= STP_PATTERN_RESET;
        end
        else if (do_write && wstrb_q[0])
        begin
            if (awaddr_q == STP_CTRL_ADDR)
            begin
                ctrl_q <= wdata_q[2:0];
            end
            if (awaddr_q == STP_PATTERN_ADDR)
            begin
                pattern_q <= wdata_q[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read

    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= STP_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_q <= 1'b1;
            rresp_q <= STP_RESP_OKAY;
            unique case (s_axi_araddr)
                STP_CTRL_ADDR: rdata_q <= {29'h0, ctrl_q};
                STP_STATUS_ADDR: rdata_q <= {14'h0, state_q, frames_q};
                STP_PATTERN_ADDR: rdata_q <= {24'h0, pattern_q};
                default:
                begin
                    rdata_q <= 32'h0;
                    rresp_q <= STP_RESP_SLVERR;
                end
            endcase
        end
        else if (rvalid_q && s_axi_rready)
        begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    ////////////////////////////////////////////////////////////////////////////
    // Payload source; aclk is the one clock shared with the framer

    assign tmode = stp_decode_mode(ctrl_q[STP_CTRL_TRS_LSB +: 2]);
    assign enable = ctrl_q[STP_CTRL_EN_BIT] && tmode != STP_TM_LOOP;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || !enable)
        begin
            state_q <= STP_HS_IDLE;
            data_q <= 1'b0;
            ref_q <= 1'b0;
            idx_q <= 3'h0;
            frames_q <= 16'h0;
        end
        else
        begin
            ref_q <= 1'b0; // [RULE13]
            unique case (state_q)
                STP_HS_IDLE:
                begin
                    state_q <= STP_HS_START;
                end
                STP_HS_START:
                begin
                    if (tmode == STP_TM_SLAVE)
                    begin
                        ref_q <= 1'b1; // [RULE18]
                        state_q <= STP_HS_RUN;
                    end
                    else if (link.transmit_frame_boundary)
                    begin
                        state_q <= STP_HS_RUN; // [RULE10]
                    end
                end
                STP_HS_RUN:
                begin
                    // Hold the bit over the overhead slot; it is filler there
                    if (!link.transmit_overhead_indicator)
                    begin
                        data_q <= pattern_q[3'h7 - idx_q]; // [RULE6] [RULE7] [RULE15]
                        idx_q <= idx_q + 3'h1;
                    end
                    if (link.transmit_frame_boundary)
                    begin
                        frames_q <= frames_q + 16'h1; // [RULE10]
                        ref_q <= (tmode == STP_TM_SLAVE); // [RULE18]
                    end
                end
                default:
                begin
                    state_q <= STP_HS_IDLE;
                end
            endcase
        end
    end

    assign link.transmit_serial_payload = data_q;
    assign link.transmit_frame_reference = ref_q;

endmodule // stp_tx_payload_sys

/* test/stp_link_asserts.sv */
// Concurrent checks on the serial transmit payload link between the two ends
`timescale 1ns/10ps
module stp_link_asserts
    import stp_pkg::*;
#(
    parameter int FRAME_BITS = STP_FRAME_BITS,
    parameter int BLOCK_BITS = STP_BLOCK_BITS
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic transmit_serial_payload,
    input wire logic transmit_frame_reference,
    input wire logic transmit_frame_boundary,
    input wire logic transmit_overhead_indicator
);
    localparam int NBLK = FRAME_BITS / BLOCK_BITS;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////////////
    // Spacing trusted only after one full block; a reference restart breaks it
    int gap_q;
    logic seen_q;
    int blk_q;

    always_ff @(posedge aclk)
    begin
        if (!aresetn || transmit_frame_reference)
        begin
            gap_q <= 0;
            seen_q <= 1'b0;
        end
        else if (transmit_overhead_indicator)
        begin
            gap_q <= 0;
            seen_q <= 1'b1;
        end
        else
        begin
            gap_q <= gap_q + 1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn || transmit_frame_reference || transmit_frame_boundary)
        begin
            blk_q <= 0;
        end
        else if (transmit_overhead_indicator)
        begin
            blk_q <= blk_q + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    a_bound_one_bit: assert property (transmit_frame_boundary |=> !transmit_frame_boundary)
        else $error("Frame boundary high for more than one bit");
    a_bound_last_ovh: assert property (transmit_frame_boundary |-> transmit_overhead_indicator)
        else $error("Frame boundary without overhead warning");
    a_ind_one_bit: assert property (transmit_overhead_indicator |=> (!transmit_overhead_indicator) [*8])
        else $error("Overhead indicator too long or too close");
    a_ind_block_gap: assert property (transmit_overhead_indicator && seen_q && !transmit_frame_reference
        |-> gap_q == BLOCK_BITS - 1)
        else $error("Overhead indicator spacing wrong");
    a_frame_blocks: assert property (transmit_frame_boundary |-> blk_q == NBLK - 1)
        else $error("Wrong number of blocks in a frame");
    a_hold_after_ind: assert property (transmit_overhead_indicator |=> $stable(transmit_serial_payload))
        else $error("Payload bit changed across overhead slot");
    a_ref_one_bit: assert property (transmit_frame_reference |=> !transmit_frame_reference)
        else $error("Frame reference high for more than one bit");
    a_ref_first_bit: assert property (transmit_frame_reference
        |-> !transmit_frame_boundary && !transmit_overhead_indicator)
        else $error("Frame reference not on a first frame bit");
endmodule // stp_link_asserts

/* test/test_serial_tx_payload_input_local_timing.sv */
// Testbench joining the framer end and the system end over the payload link
`timescale 1ns/10ps
module test_serial_tx_payload_input_local_timing;
    import stp_pkg::*;

    localparam int FRAME_BITS = 680;
    localparam int BLOCK_BITS = STP_BLOCK_BITS;
    localparam int BYTES = (FRAME_BITS - FRAME_BITS / BLOCK_BITS) / STP_BYTE_BITS;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic width_pin = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic [7:0] reg_rdata, payload_byte;
    logic payload_byte_valid, frame_done, local_timing_active;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;

    stp_link_if stp_link_if_inst();

    stp_tx_payload_dev #(.FRAME_BITS(FRAME_BITS), .BLOCK_BITS(BLOCK_BITS)) stp_tx_payload_dev_inst
        (.aclk(aclk), .aresetn(aresetn), .link(stp_link_if_inst.dev), .payload_width_select_pin(width_pin),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_rdata(reg_rdata),
        .payload_byte(payload_byte), .payload_byte_valid(payload_byte_valid), .frame_done(frame_done),
        .local_timing_active(local_timing_active));

    stp_tx_payload_sys #(.AW(8)) stp_tx_payload_sys_inst
        (.aclk(aclk), .aresetn(aresetn), .link(stp_link_if_inst.sys), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    stp_link_asserts #(.FRAME_BITS(FRAME_BITS), .BLOCK_BITS(BLOCK_BITS)) stp_link_asserts_inst
        (.aclk(aclk), .aresetn(aresetn), .transmit_serial_payload(stp_link_if_inst.transmit_serial_payload),
        .transmit_frame_reference(stp_link_if_inst.transmit_frame_reference),
        .transmit_frame_boundary(stp_link_if_inst.transmit_frame_boundary),
        .transmit_overhead_indicator(stp_link_if_inst.transmit_overhead_indicator));

    initial
    begin
        forever #50 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Ceiling well above the roughly 9000 cycles the sequence needs
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            err_count = err_count + 1;
            $display("BAD %0t timeout", $time);
            summarize();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic do_reset(input logic width);
        @(posedge aclk);
        aresetn <= 1'b0;
        width_pin <= width;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        // Width strap needs two edges to pass its synchroniser
        repeat (3) @(posedge aclk);
    endtask

    // Mode register port: write optional, read back two edges later
    task automatic dev_reg(input logic [15:0] a, input logic [7:0] d, input logic we, output logic [7:0] q);
        @(posedge aclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= we;
        @(posedge aclk);
        reg_write <= 1'b0;
        repeat (2) @(posedge aclk);
        q = reg_rdata;
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(posedge aclk);
            if (!aw_done && awready === 1'b1)
            begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1)
            begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_registers();
        logic [7:0] q;
        logic [31:0] d;
        logic [1:0] r;
        do_reset(1'b0);
        dev_reg(STP_MODE_REG_ADDR, 8'h00, 1'b0, q);
        check(q, STP_MODE_RESET, "mode reset");
        dev_reg(STP_MODE_REG_ADDR, 8'h5A, 1'b1, q);
        check(q, 8'h5A, "mode readback");
        dev_reg(16'h1101, 8'hFF, 1'b1, q);
        check(q, 8'h00, "other address reads zero");
        dev_reg(STP_MODE_REG_ADDR, 8'h00, 1'b0, q);
        check(q, 8'h5A, "other address write ignored");
        axi_read(STP_PATTERN_ADDR, d, r);
        check(d, {24'h0, STP_PATTERN_RESET}, "pattern reset");
        axi_read(STP_CTRL_ADDR, d, r);
        check(d, 32'h0, "ctrl reset");
        axi_read(8'h0C, d, r);
        check(d, 32'h0, "unmapped read data");
        check(r, STP_RESP_SLVERR, "unmapped read response");
        axi_write(8'h0C, 32'h1, r);
        check(r, STP_RESP_SLVERR, "unmapped write");
    endtask

    // No frames when loop timing or nibble width is chosen
    task automatic t_idle(input logic width, input logic [1:0] sel);
        logic [7:0] q;
        int hits;
        hits = 0;
        do_reset(width);
        dev_reg(STP_MODE_REG_ADDR, {6'h0, sel}, 1'b1, q);
        check(local_timing_active, 1'b0, "local timing off");
        repeat (2 * FRAME_BITS)
        begin
            @(posedge aclk);
            if (frame_done !== 1'b0 || stp_link_if_inst.transmit_frame_boundary !== 1'b0)
                hits++;
        end
        check(hits, 0, "idle frame activity");
    endtask

    // Both ends in one local-timing mode; every byte captured in the third frame must be the pattern
    task automatic t_run(input logic [1:0] sel, input logic [7:0] pat);
        logic [7:0] q;
        logic [31:0] d;
        logic [1:0] r;
        int frames, bytes;
        frames = 0;
        bytes = 0;
        do_reset(1'b0);
        dev_reg(STP_MODE_REG_ADDR, {6'h0, sel}, 1'b1, q);
        check(local_timing_active, 1'b1, "local timing on");
        axi_write(STP_PATTERN_ADDR, {24'h0, pat}, r);
        axi_write(STP_CTRL_ADDR, {29'h0, 1'b1, sel}, r);
        check(r, STP_RESP_OKAY, "ctrl write");
        while (frames < 3)
        begin
            @(posedge aclk);
            if (frames == 2 && payload_byte_valid === 1'b1)
            begin
                bytes++;
                check(payload_byte, pat, "captured byte");
            end
            if (sel[1])
                check(stp_link_if_inst.transmit_frame_reference, 1'b0, "reference low in master mode");
            if (frame_done === 1'b1)
                frames++;
        end
        check(bytes, BYTES, "bytes per frame");
        axi_read(STP_STATUS_ADDR, d, r);
        check(d[17:16], STP_HS_RUN, "source running");
        // Slave source counts its first frame; master source waits one boundary
        check(d[15:0], (sel == 2'b01) ? 32'h3 : 32'h2, "frames sent");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge aclk);
        t_registers();
        t_idle(1'b0, 2'b00);
        t_idle(1'b1, 2'b10);
        t_run(2'b01, 8'h96);
        t_run(2'b10, 8'h3C);
        t_run(2'b11, 8'hC5);
        summarize();
    end
endmodule // test_serial_tx_payload_input_local_timing
